// File: logic/e1l_params.svh
// e1l_params.svh: offsets, field positions, reset values and timing counts
// assumes a 100 MHz mclk and the plain register port of e1l_ctrl
`ifndef E1L_PARAMS_SVH
`define E1L_PARAMS_SVH

// ****************
// timing
// ****************
`define E1L_CLK_MHZ 100
`define E1L_BIT_NS 488
`define E1L_BIT_CYC ((`E1L_BIT_NS * `E1L_CLK_MHZ) / 1000)
`define E1L_HALF_CYC (`E1L_BIT_CYC / 2)
`define E1L_IDLE_BITS 4
`define E1L_IDLE_CYC (`E1L_BIT_CYC * `E1L_IDLE_BITS)
`define E1L_LOS_SET_ZEROS 32
`define E1L_LOS_WIN_BITS 32
`define E1L_LOS_CLR_MARKS 4
`define E1L_LOS_CLR_RUN 16

// ****************
// registers
// ****************
`define E1L_REG_STATUS 4'h0
`define E1L_REG_MASK 4'h4
`define E1L_REG_MODE 4'h8
`define E1L_EV_LOS_ON 0
`define E1L_EV_LOS_OFF 1
`define E1L_EV_BOTH 2
`define E1L_MASK_RST 3'h0
`define E1L_MODE_CLOCKED 4
`define E1L_MODE_LOS 5

`endif

// File: logic/e1l_pkg.sv
// e1l_pkg.sv: types shared by the line interface control logic
// assumes nothing beyond a SystemVerilog compiler
package e1l_pkg;

  // ****************
  // loop modes, one-hot
  // ****************
  typedef enum logic [3:0] {
    E1L_NORMAL = 4'h1,
    E1L_NEAR = 4'h2,
    E1L_FAR = 4'h4,
    E1L_ICT = 4'h8
  } e1l_mode_e;

  // ****************
  // dual-rail mark pair
  // ****************
  typedef struct packed {
    logic pos;
    logic neg;
  } e1l_mark_s;

endpackage

// File: logic/e1l_ctrl.sv
// e1l_ctrl.sv: digital control of a single-channel E1 line interface
// assumes all pins synchronous to mclk; line pins carry one bit per rail
//
// Function
// R1: clocked mode samples marks on clock fall
// R2: clockless mode leaves transmit clock idle
// R3: clocked mode marks are bit-wide NRZ; code sends the same 24-cycle half-bit RZ pulses as in clockless mode
// R4: clockless mode marks are RZ pulses
// R5: near select high enters local loopback
// R6: local loopback feeds line out to receiver
// R7: far select high enters remote loopback
// R8: remote loopback sends received marks back out
// R9: both selects high tri-state all outputs; code gives reg_rdata and irq no enable, so they stay driven
// R10: line pulses follow the E1 bit rate
// R11: loss of signal set and cleared per G.775
// R12: positive line pulse gives positive mark out
// R13: negative line pulse gives negative mark out
// R14: signal lost flag high during loss
// R15: clock edges mean clocked, idle means clockless
// R16: never both marks in one bit
`timescale 1ns/1ps
`include "e1l_params.svh"

module e1l_ctrl
  import e1l_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // transmit side from terminal equipment
  input wire logic transmit_sample_clock,
  input wire logic positive_mark_in,
  input wire logic negative_mark_in,
  // loop selects
  input wire logic near_loop_select,
  input wire logic far_loop_select,
  // receive line
  input wire logic line_in_a,
  input wire logic line_in_b,
  // transmit line
  output logic line_out_a,
  output logic line_out_a_oe,
  output logic line_out_b,
  output logic line_out_b_oe,
  // receive marks and loss flag
  output logic positive_mark_out,
  output logic positive_mark_out_oe,
  output logic negative_mark_out,
  output logic negative_mark_out_oe,
  output logic signal_lost_flag,
  output logic signal_lost_flag_oe,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq
);

  localparam logic [5:0] HALF_CYC = 6'(`E1L_HALF_CYC);
  localparam logic [5:0] BIT_LAST = 6'(`E1L_BIT_CYC - 1);
  localparam logic [7:0] IDLE_LAST = 8'(`E1L_IDLE_CYC - 1);
  localparam logic [5:0] LOS_SET = 6'(`E1L_LOS_SET_ZEROS);
  localparam logic [4:0] WIN_LAST = 5'(`E1L_LOS_WIN_BITS - 1);
  localparam logic [5:0] CLR_MARKS = 6'(`E1L_LOS_CLR_MARKS);
  localparam logic [5:0] CLR_RUN = 6'(`E1L_LOS_CLR_RUN);

  function automatic e1l_mode_e e1l_decode_mode(input logic near_sel, input logic far_sel);
    if (near_sel && far_sel) begin
      return E1L_ICT;
    end else if (near_sel) begin
      return E1L_NEAR;
    end else if (far_sel) begin
      return E1L_FAR;
    end else begin
      return E1L_NORMAL;
    end
  endfunction

  // ****************
  // loop mode
  // ****************
  e1l_mode_e mode_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= E1L_NORMAL;
    end else begin
      mode_q <= e1l_decode_mode(near_loop_select, far_loop_select); // R5 R7 R9
    end
  end

  // ****************
  // transmit clock detection
  // ****************
  logic transmit_sample_clock_alt_prev_q;
  logic clocked_q;
  logic [7:0] idle_cnt_q;
  logic transmit_sample_clock_alt_fall;
  logic clocked_now;

  assign transmit_sample_clock_alt_fall = transmit_sample_clock_alt_prev_q && !transmit_sample_clock;
  assign clocked_now = clocked_q || transmit_sample_clock_alt_fall;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      transmit_sample_clock_alt_prev_q <= 1'b0;
      clocked_q <= 1'b0;
      idle_cnt_q <= 8'h00;
    end else begin
      transmit_sample_clock_alt_prev_q <= transmit_sample_clock;
      if (transmit_sample_clock_alt_fall) begin
        clocked_q <= 1'b1; // R15
        idle_cnt_q <= 8'h00;
      end else if (idle_cnt_q == IDLE_LAST) begin
        clocked_q <= 1'b0; // R15 R2
      end else begin
        idle_cnt_q <= idle_cnt_q + 8'h01;
      end
    end
  end

  // ****************
  // receive edge detection
  // ****************
  e1l_mark_s rx_src;
  e1l_mark_s rx_prev_q;
  e1l_mark_s rx_rise;
  logic line_a_q;
  logic line_b_q;

  always_comb begin
    if (mode_q == E1L_NEAR) begin
      rx_src = '{pos: line_a_q, neg: line_b_q}; // R6
    end else begin
      rx_src = '{pos: line_in_a, neg: line_in_b};
    end
  end

  assign rx_rise.pos = rx_src.pos && !rx_prev_q.pos;
  assign rx_rise.neg = rx_src.neg && !rx_prev_q.neg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_prev_q <= '0;
    end else begin
      rx_prev_q <= rx_src;
    end
  end

  // ****************
  // transmit pulse generation
  // ****************
  e1l_mark_s pin_prev_q;
  e1l_mark_s tx_start;
  logic [5:0] tx_cnt_q;
  logic both_ev;

  always_comb begin
    case (mode_q)
      E1L_FAR: begin
        tx_start = rx_rise; // R8
      end
      default: begin
        if (clocked_now) begin
          tx_start.pos = transmit_sample_clock_alt_fall && positive_mark_in; // R1 R3
          tx_start.neg = transmit_sample_clock_alt_fall && negative_mark_in; // R1 R3
        end else begin
          tx_start.pos = positive_mark_in && !pin_prev_q.pos; // R4
          tx_start.neg = negative_mark_in && !pin_prev_q.neg; // R4
        end
      end
    endcase
  end

  assign both_ev = tx_start.pos && tx_start.neg; // R16

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_q <= '0;
    end else begin
      pin_prev_q <= '{pos: positive_mark_in, neg: negative_mark_in};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_cnt_q <= 6'h00;
      line_a_q <= 1'b0;
      line_b_q <= 1'b0;
    end else if (tx_cnt_q == 6'h00) begin
      if ((tx_start.pos || tx_start.neg) && !both_ev) begin
        tx_cnt_q <= HALF_CYC; // R10
        line_a_q <= tx_start.pos;
        line_b_q <= tx_start.neg;
      end
    end else begin
      tx_cnt_q <= tx_cnt_q - 6'h01;
      if (tx_cnt_q == 6'h01) begin
        line_a_q <= 1'b0;
        line_b_q <= 1'b0;
      end
    end
  end

  // ****************
  // receive mark outputs
  // ****************
  logic [5:0] rxp_cnt_q;
  logic [5:0] rxn_cnt_q;
  logic rxp_q;
  logic rxn_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxp_cnt_q <= 6'h00;
      rxp_q <= 1'b0;
    end else if (rx_rise.pos) begin
      rxp_cnt_q <= HALF_CYC - 6'h01; // R12
      rxp_q <= 1'b1;
    end else if (rxp_cnt_q != 6'h00) begin
      rxp_cnt_q <= rxp_cnt_q - 6'h01;
    end else begin
      rxp_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxn_cnt_q <= 6'h00;
      rxn_q <= 1'b0;
    end else if (rx_rise.neg) begin
      rxn_cnt_q <= HALF_CYC - 6'h01; // R13
      rxn_q <= 1'b1;
    end else if (rxn_cnt_q != 6'h00) begin
      rxn_cnt_q <= rxn_cnt_q - 6'h01;
    end else begin
      rxn_q <= 1'b0;
    end
  end

  // ****************
  // loss of signal
  // ****************
  logic [5:0] bit_cnt_q;
  logic mark_seen_q;
  logic [5:0] zero_run_q;
  logic [4:0] win_cnt_q;
  logic [5:0] win_marks_q;
  logic win_bad_q;
  logic los_q;
  logic bit_tick;
  logic bit_mark;
  logic [5:0] zrun_d;
  logic los_on_ev;
  logic los_off_ev;

  assign bit_tick = bit_cnt_q == BIT_LAST;
  assign bit_mark = mark_seen_q || rx_rise.pos || rx_rise.neg;
  assign zrun_d = bit_mark ? 6'h00 : ((zero_run_q == 6'h3F) ? 6'h3F : zero_run_q + 6'h01);
  assign los_on_ev = bit_tick && !los_q && zrun_d == LOS_SET; // R11
  assign los_off_ev = bit_tick && los_q && win_cnt_q == WIN_LAST && !win_bad_q
                      && zrun_d < CLR_RUN
                      && (win_marks_q + {5'h00, bit_mark}) >= CLR_MARKS; // R11

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= 6'h00;
      mark_seen_q <= 1'b0;
      zero_run_q <= 6'h00;
    end else begin
      bit_cnt_q <= bit_tick ? 6'h00 : bit_cnt_q + 6'h01;
      mark_seen_q <= bit_tick ? 1'b0 : bit_mark;
      if (bit_tick) begin
        zero_run_q <= zrun_d;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      los_q <= 1'b0;
      win_cnt_q <= 5'h00;
      win_marks_q <= 6'h00;
      win_bad_q <= 1'b0;
    end else if (bit_tick) begin
      if (los_on_ev) begin
        los_q <= 1'b1; // R11
      end else if (los_off_ev) begin
        los_q <= 1'b0; // R11
      end
      if (!los_q || win_cnt_q == WIN_LAST) begin
        win_cnt_q <= 5'h00;
        win_marks_q <= 6'h00;
        win_bad_q <= 1'b0;
      end else begin
        win_cnt_q <= win_cnt_q + 5'h01;
        win_marks_q <= win_marks_q + {5'h00, bit_mark};
        win_bad_q <= win_bad_q || zrun_d >= CLR_RUN;
      end
    end
  end

  // ****************
  // pin outputs
  // ****************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      line_out_a <= 1'b0;
      line_out_b <= 1'b0;
      positive_mark_out <= 1'b0;
      negative_mark_out <= 1'b0;
      signal_lost_flag <= 1'b0;
    end else begin
      line_out_a <= line_a_q;
      line_out_b <= line_b_q;
      positive_mark_out <= rxp_q;
      negative_mark_out <= rxn_q;
      signal_lost_flag <= los_q; // R14
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      line_out_a_oe <= 1'b1;
      line_out_b_oe <= 1'b1;
      positive_mark_out_oe <= 1'b1;
      negative_mark_out_oe <= 1'b1;
      signal_lost_flag_oe <= 1'b1;
    end else begin
      line_out_a_oe <= mode_q != E1L_ICT; // R9
      line_out_b_oe <= mode_q != E1L_ICT; // R9
      positive_mark_out_oe <= mode_q != E1L_ICT; // R9
      negative_mark_out_oe <= mode_q != E1L_ICT; // R9
      signal_lost_flag_oe <= mode_q != E1L_ICT; // R9
    end
  end

  // ****************
  // registers and interrupt
  // ****************
  logic [2:0] status_q;
  logic [2:0] mask_q;
  logic [2:0] ev;
  logic status_rd;

  assign ev = {both_ev, los_off_ev, los_on_ev};
  assign status_rd = reg_rd && reg_addr == `E1L_REG_STATUS;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= 3'h0;
    end else begin
      // set wins over the read clear
      status_q <= (status_rd ? 3'h0 : status_q) | ev;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= `E1L_MASK_RST;
    end else if (reg_wr && reg_addr == `E1L_REG_MASK) begin
      mask_q <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == `E1L_REG_STATUS) begin
      reg_rdata <= {5'h00, status_q};
    end else if (reg_addr == `E1L_REG_MASK) begin
      reg_rdata <= {5'h00, mask_q};
    end else if (reg_addr == `E1L_REG_MODE) begin
      reg_rdata <= {2'h0, los_q, clocked_q, mode_q};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status_rd ? 3'h0 : status_q) | ev) & mask_q);
    end
  end

  // ****************
  // checks
  // ****************
  logic [5:0] hi_cnt_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt_q <= 6'h00;
    end else begin
      hi_cnt_q <= line_a_q ? hi_cnt_q + 6'h01 : 6'h00;
    end
  end

  property p_r1;
    @(posedge mclk) disable iff (!rst_n)
    mode_q == E1L_NORMAL && transmit_sample_clock_alt_fall && positive_mark_in && !negative_mark_in
      && tx_cnt_q == 6'h00 |=> line_a_q ##1 line_out_a;
  endproperty
  a_r1: assert property (p_r1) else $error("clocked mark not sampled on fall"); // R1

  property p_r5;
    @(posedge mclk) disable iff (!rst_n)
    near_loop_select && !far_loop_select |=> mode_q == E1L_NEAR;
  endproperty
  a_r5: assert property (p_r5) else $error("near select did not loop"); // R5

  property p_r6;
    @(posedge mclk) disable iff (!rst_n)
    mode_q == E1L_NEAR && $rose(line_a_q) |=> rxp_q ##1 positive_mark_out;
  endproperty
  a_r6: assert property (p_r6) else $error("local loop lost a mark"); // R6

  property p_r7;
    @(posedge mclk) disable iff (!rst_n)
    far_loop_select && !near_loop_select |=> mode_q == E1L_FAR;
  endproperty
  a_r7: assert property (p_r7) else $error("far select did not loop"); // R7

  property p_r8;
    @(posedge mclk) disable iff (!rst_n)
    mode_q == E1L_FAR && rx_rise.neg && !rx_rise.pos && tx_cnt_q == 6'h00
      |=> line_b_q && !line_a_q;
  endproperty
  a_r8: assert property (p_r8) else $error("remote loop lost a mark"); // R8

  property p_r9;
    @(posedge mclk) disable iff (!rst_n)
    mode_q == E1L_ICT |=> !line_out_a_oe && !line_out_b_oe && !positive_mark_out_oe
      && !negative_mark_out_oe && !signal_lost_flag_oe;
  endproperty
  a_r9: assert property (p_r9) else $error("test mode left a pin driven"); // R9

  property p_r10;
    @(posedge mclk) disable iff (!rst_n)
    $fell(line_a_q) |-> hi_cnt_q == HALF_CYC;
  endproperty
  a_r10: assert property (p_r10) else $error("line pulse width wrong"); // R10

  property p_r11;
    @(posedge mclk) disable iff (!rst_n)
    $rose(los_q) |-> zero_run_q == LOS_SET ##2 signal_lost_flag;
  endproperty
  a_r11: assert property (p_r11) else $error("loss declared early"); // R11 R14

  property p_r12;
    @(posedge mclk) disable iff (!rst_n)
    rx_rise.pos |=> rxp_q [*8];
  endproperty
  a_r12: assert property (p_r12) else $error("positive mark out too short"); // R12

  property p_r15;
    @(posedge mclk) disable iff (!rst_n)
    transmit_sample_clock_alt_fall |=> clocked_q && idle_cnt_q == 8'h00;
  endproperty
  a_r15: assert property (p_r15) else $error("clock edge not seen"); // R15

endmodule

// File: sim/e1l_term_model.sv
// e1l_term_model.sv: terminal equipment driving the transmit marks
// assumes a 100 MHz mclk and a bit period of 48 mclk cycles
`timescale 1ns/1ps

module e1l_term_model (
  // clock
  input wire logic mclk,
  // transmit pins toward the block
  output logic transmit_sample_clock,
  output logic positive_mark_in,
  output logic negative_mark_in
);
  // ****************
  // drive tasks
  // ****************
  initial begin
    transmit_sample_clock = 1'b0;
    positive_mark_in = 1'b0;
    negative_mark_in = 1'b0;
  end

  // marks move with the clock rise, block samples at the fall
  task automatic clocked_run(input logic [7:0] p, input logic [7:0] n);
    for (int i = 7; i >= 0; i--) begin
      @(posedge mclk);
      transmit_sample_clock <= 1'b1;
      positive_mark_in <= p[i];
      negative_mark_in <= n[i];
      repeat (24) @(posedge mclk);
      transmit_sample_clock <= 1'b0;
      repeat (23) @(posedge mclk);
    end
    @(posedge mclk);
    positive_mark_in <= 1'b0;
    negative_mark_in <= 1'b0;
  endtask

  // clock stays idle, one quarter-bit (12 mclk) pulse per mark
  task automatic rz_pulse(input logic p, input logic n);
    @(posedge mclk);
    positive_mark_in <= p;
    negative_mark_in <= n;
    repeat (12) @(posedge mclk);
    positive_mark_in <= 1'b0;
    negative_mark_in <= 1'b0;
    repeat (36) @(posedge mclk);
  endtask
endmodule

// File: sim/e1l_ctrl_tb.sv
// e1l_ctrl_tb.sv: self-checking bench for the line interface control
// assumes e1l_term_model drives the transmit pins; bench drives the rest
`timescale 1ns/1ps
`include "e1l_params.svh"

module e1l_ctrl_tb
  import e1l_pkg::*;
;
  logic mclk, rst_n, near_loop_select, far_loop_select, line_in_a, line_in_b;
  logic transmit_sample_clock, positive_mark_in, negative_mark_in;
  logic line_out_a, line_out_b, positive_mark_out, negative_mark_out, signal_lost_flag, irq;
  logic [3:0] reg_addr, obs_q;
  logic [7:0] reg_wdata, reg_rdata, rd;
  logic reg_wr, reg_rd;
  wire [4:0] oe;
  wire [3:0] obs;
  int fails, checks_done, n, c0, c1;
  int cnt [4] = '{0, 0, 0, 0};

  e1l_ctrl dut (
    .mclk(mclk), .rst_n(rst_n), .transmit_sample_clock(transmit_sample_clock),
    .positive_mark_in(positive_mark_in), .negative_mark_in(negative_mark_in),
    .near_loop_select(near_loop_select), .far_loop_select(far_loop_select),
    .line_in_a(line_in_a), .line_in_b(line_in_b),
    .line_out_a(line_out_a), .line_out_a_oe(oe[0]), .line_out_b(line_out_b),
    .line_out_b_oe(oe[1]), .positive_mark_out(positive_mark_out),
    .positive_mark_out_oe(oe[2]), .negative_mark_out(negative_mark_out),
    .negative_mark_out_oe(oe[3]), .signal_lost_flag(signal_lost_flag),
    .signal_lost_flag_oe(oe[4]), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq)
  );

  e1l_term_model u_term (
    .mclk(mclk), .transmit_sample_clock(transmit_sample_clock),
    .positive_mark_in(positive_mark_in), .negative_mark_in(negative_mark_in)
  );

  assign obs = {negative_mark_out, positive_mark_out, line_out_b, line_out_a};

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ****************
  // pulse counters
  // ****************
  always @(posedge mclk) begin
    for (int i = 0; i < 4; i++) if (obs[i] === 1'b1 && obs_q[i] !== 1'b1) cnt[i]++;
    obs_q <= obs;
  end

  // ****************
  // tasks
  // ****************
  task automatic results();
    if (fails == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic guard(input int k, input int lim);
    if (k >= lim) begin
      fails++;
      $display("[FAIL] %0t wait expired", $time);
      results();
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  task automatic line_pulse(input logic b);
    @(posedge mclk);
    if (b) line_in_b <= 1'b1;
    else line_in_a <= 1'b1;
    repeat (12) @(posedge mclk);
    line_in_a <= 1'b0;
    line_in_b <= 1'b0;
  endtask

  // latency from the stimulus edge, then width of the pulse
  task automatic pulse_chk(input int idx, input string what);
    int k, w;
    k = 0;
    w = 0;
    @(posedge mclk);
    do begin
      @(posedge mclk);
      #1 k++;
    end while (obs[idx] !== 1'b1 && k < 60);
    guard(k, 60);
    while (obs[idx] === 1'b1 && w < 60) begin
      @(posedge mclk);
      #1 w++;
    end
    chk(8'(k), 8'h02, what);
    chk(8'(w), 8'h18, what);
  endtask

  // ****************
  // sequence
  // ****************
  initial begin
    rst_n = 1'b0;
    near_loop_select = 1'b0;
    far_loop_select = 1'b0;
    line_in_a = 1'b0;
    line_in_b = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (19) @(posedge mclk);
    #1 chk({3'h0, oe}, 8'h1F, "enables in reset");
    chk({4'h0, obs}, 8'h00, "outputs in reset");
    @(posedge mclk);
    rst_n <= 1'b1;
    reg_read(`E1L_REG_MODE);
    chk(rd, 8'(E1L_NORMAL), "mode after reset");
    reg_read(`E1L_REG_MASK);
    chk(rd, 8'h00, "mask reset");
    reg_write(4'hC, 8'hFF);
    reg_read(4'hC);
    chk(rd, 8'h00, "unmapped read");
    reg_write(`E1L_REG_MASK, 8'h01);
    n = 0;
    while (signal_lost_flag !== 1'b1 && n < 2000) begin
      @(posedge mclk);
      #1 n++;
    end
    guard(n, 2000);
    chk(8'(n >= 1480 && n <= 1640), 8'h01, "loss set time");
    chk(8'(irq), 8'h01, "irq on loss");
    reg_read(`E1L_REG_STATUS);
    chk(rd, 8'h01, "status loss set");
    repeat (2) @(posedge mclk);
    #1 chk(8'(irq), 8'h00, "irq after read");
    reg_read(`E1L_REG_MODE);
    chk(rd, 8'h21, "mode with loss");
    n = 0;
    while (signal_lost_flag !== 1'b0 && n < 90) begin
      line_pulse(1'b0);
      repeat (35) @(posedge mclk);
      n++;
    end
    guard(n, 90);
    reg_write(`E1L_REG_MASK, 8'h04);
    repeat (2) @(posedge mclk);
    #1 chk(8'(irq), 8'h00, "masked event");
    reg_read(`E1L_REG_STATUS);
    chk(rd, 8'h02, "status loss clear");
    fork line_pulse(1'b0); pulse_chk(2, "rx pos"); join
    fork line_pulse(1'b1); pulse_chk(3, "rx neg"); join
    fork u_term.rz_pulse(1'b1, 1'b0); pulse_chk(0, "tx rz pos"); join
    fork u_term.rz_pulse(1'b0, 1'b1); pulse_chk(1, "tx rz neg"); join
    c0 = cnt[0];
    c1 = cnt[1];
    u_term.clocked_run(8'h91, 8'h44);
    reg_read(`E1L_REG_MODE);
    chk(rd & 8'h1F, 8'h11, "clocked mode seen");
    chk(8'(cnt[0] - c0), 8'h03, "clocked pos count");
    chk(8'(cnt[1] - c1), 8'h02, "clocked neg count");
    c0 = cnt[0] + cnt[1];
    u_term.clocked_run(8'h01, 8'h01);
    repeat (4) @(posedge mclk);
    chk(8'(cnt[0] + cnt[1] - c0), 8'h00, "both marks sent");
    #1 chk(8'(irq), 8'h01, "irq on both marks");
    reg_read(`E1L_REG_STATUS);
    chk(rd & 8'h04, 8'h04, "status both marks");
    @(posedge mclk);
    near_loop_select <= 1'b1;
    repeat (3) @(posedge mclk);
    reg_read(`E1L_REG_MODE);
    chk(rd & 8'h0F, 8'(E1L_NEAR), "near mode");
    repeat (`E1L_IDLE_CYC) @(posedge mclk);
    reg_read(`E1L_REG_MODE);
    chk(rd & 8'h10, 8'h00, "clockless after idle");
    c0 = cnt[2];
    c1 = cnt[3];
    u_term.rz_pulse(1'b1, 1'b0);
    line_pulse(1'b1);
    repeat (4) @(posedge mclk);
    chk(8'(cnt[2] - c0), 8'h01, "near loop return");
    chk(8'(cnt[3] - c1), 8'h00, "near loop line ignored");
    @(posedge mclk);
    near_loop_select <= 1'b0;
    far_loop_select <= 1'b1;
    repeat (3) @(posedge mclk);
    reg_read(`E1L_REG_MODE);
    chk(rd & 8'h0F, 8'(E1L_FAR), "far mode");
    c0 = cnt[0];
    c1 = cnt[1];
    line_pulse(1'b0);
    u_term.rz_pulse(1'b1, 1'b0);
    chk(8'(cnt[0] - c0), 8'h01, "far loop return");
    line_pulse(1'b1);
    chk(8'(cnt[1] - c1), 8'h01, "far loop neg return");
    @(posedge mclk);
    near_loop_select <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk({3'h0, oe}, 8'h00, "test mode enables");
    reg_read(`E1L_REG_MODE);
    chk(rd & 8'h0F, 8'(E1L_ICT), "test mode");
    @(posedge mclk);
    near_loop_select <= 1'b0;
    far_loop_select <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk({3'h0, oe}, 8'h1F, "normal enables");
    results();
  end
endmodule
